// file: hdl/flash_ctrl_pkg.sv
// Package for the parallel flash host controller.
// Assumes a 250 MHz clk and a flash part on an asynchronous parallel bus.
package flash_ctrl_pkg;

    // ****************************************
    // Bus widths
    // ****************************************
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;

    // ****************************************
    // Command addresses and codes
    // ****************************************
    localparam logic [16:0] UNLOCK_ADDR1   = 17'h05555;
    localparam logic [16:0] UNLOCK_ADDR2   = 17'h02AAA;
    localparam logic [16:0] LOCK_STAT_ADDR = 17'h00002;
    localparam logic [7:0]  UNLOCK_DATA1   = 8'hAA;
    localparam logic [7:0]  UNLOCK_DATA2   = 8'h55;
    localparam logic [7:0]  CMD_ERASE_PRE  = 8'h80;
    localparam logic [7:0]  CMD_CHIP_ERASE = 8'h10;
    localparam logic [7:0]  CMD_SECT_ERASE = 8'h30;
    localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
    localparam logic [7:0]  CMD_LOCKOUT    = 8'h40;
    localparam logic [7:0]  CMD_ID_ENTRY   = 8'h90;
    localparam logic [7:0]  CMD_ID_EXIT    = 8'hF0;

    // ****************************************
    // Sector addresses
    // ****************************************
    localparam logic [16:0] SECT_BOOT   = 17'h01000;
    localparam logic [16:0] SECT_PARAM1 = 17'h02000;
    localparam logic [16:0] SECT_PARAM2 = 17'h03000;
    localparam logic [16:0] SECT_MAIN   = 17'h1F000;
    localparam logic [16:0] BOOT_TOP    = 17'h01FFF;

    // ****************************************
    // Status bit positions
    // ****************************************
    localparam int DQ_LOCK   = 0;
    localparam int DQ_TOGGLE = 6;
    localparam int DQ_POLL   = 7;

    // ****************************************
    // Bus timing
    // ****************************************
    localparam int CLK_PS       = 4000;
    localparam int ACCESS_NS    = 90;
    localparam int STROBE_NS    = 40;
    localparam int SETUP_NS     = 8;
    localparam int ACCESS_CYC   = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int STROBE_CYC   = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int SETUP_CYC    = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W        = 8;
    localparam int POLL_LIMIT   = 32'd100000000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        OP_READ, OP_PROGRAM, OP_CHIP_ERASE, OP_SECT_ERASE,
        OP_LOCKOUT, OP_LOCK_QUERY
    } op_t;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              byteMode;
    } req_t;

    typedef struct packed {
        logic              done;
        logic              timeout;
        logic [DATA_W-1:0] data;
    } rsp_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              write;
    } cycle_t;

endpackage

// file: hdl/flash_bus_cycle.sv
// One flash bus cycle: a write strobe or a timed read.
// Assumes the flash sits on the pins driven here; read data is synchronised.
`timescale 1ns/1ps
module flash_bus_cycle (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst,
    // Cycle request
    input  wire logic                              start,
    input  wire flash_ctrl_pkg::cycle_t            cyc,
    output logic                                   busy,
    output logic                                   done,
    output logic [flash_ctrl_pkg::DATA_W-1:0]      rdData,
    // Flash pins
    output logic                                   chipSel_n,
    output logic                                   outEn_n,
    output logic                                   writeStb_n,
    output logic [flash_ctrl_pkg::ADDR_W-1:0]      addrPin,
    output logic [flash_ctrl_pkg::DATA_W-1:0]      dataOut,
    output logic                                   dataOe_n,
    input  wire logic [flash_ctrl_pkg::DATA_W-1:0] dataIn
);
    import flash_ctrl_pkg::*;

    typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} bstate_t;

    bstate_t                 state;
    logic [CNT_W-1:0]        cnt;
    logic                    isWrite;
    logic [DATA_W-1:0]       syncA;
    logic [DATA_W-1:0]       syncB;

    assign busy = (state != IDLE);

    // ****************************************
    // Read data synchroniser
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= dataIn;
            syncB <= syncA;
        end
    end

    // ****************************************
    // Cycle sequencer
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= IDLE;
            cnt        <= '0;
            isWrite    <= 1'b0;
            done       <= 1'b0;
            rdData     <= '0;
            chipSel_n  <= 1'b1;
            outEn_n    <= 1'b1;
            writeStb_n <= 1'b1;
            addrPin    <= '0;
            dataOut    <= '0;
            dataOe_n   <= 1'b1;
        end else begin
            done <= 1'b0;
            unique case (state)
                IDLE: begin
                    if (start) begin
                        addrPin   <= cyc.addr;
                        dataOut   <= cyc.data;
                        isWrite   <= cyc.write;
                        dataOe_n  <= !cyc.write;
                        chipSel_n <= 1'b0;
                        cnt       <= CNT_W'(SETUP_CYC);
                        state     <= SETUP;
                    end
                end
                SETUP: begin
                    if (cnt == '0) begin
                        writeStb_n <= !isWrite;
                        outEn_n    <= isWrite;
                        cnt        <= isWrite ? CNT_W'(STROBE_CYC) : CNT_W'(ACCESS_CYC + 2);
                        state      <= STROBE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                STROBE: begin
                    if (cnt == '0) begin
                        writeStb_n <= 1'b1;
                        outEn_n    <= 1'b1;
                        rdData     <= syncB;
                        cnt        <= CNT_W'(SETUP_CYC);
                        state      <= HOLD;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                HOLD: begin
                    chipSel_n <= 1'b1;
                    if (cnt == '0) begin
                        dataOe_n <= 1'b1;
                        done     <= 1'b1;
                        state    <= IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
            endcase
        end
    end

endmodule

// file: hdl/flash_host_ctrl.sv
// Host controller for a parallel NOR flash: reads, program, erase, lockout.
// Assumes the flash pins connect directly; user requests come on a plain port list.
//
// Overview of operation
// - Host writes commands by strobing with output enable high.
// - Host erases whichever block the caller names; erase order across blocks is left to the caller.
// - Host enables lockout with a six-cycle command sequence.
// - In identification mode, address two bit zero shows lock status.
`timescale 1ns/1ps
module flash_host_ctrl (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst,
    // User requests
    input  wire logic                              reqValid,
    output logic                                   reqReady,
    input  wire flash_ctrl_pkg::req_t              req,
    output flash_ctrl_pkg::rsp_t                   rsp,
    input  wire logic                              abort,
    input  wire logic                              overrideLock,
    // Flash pins
    output logic                                   chipSel_n,
    output logic                                   outEn_n,
    output logic                                   writeStb_n,
    output logic                                   flashReset_n,
    output logic                                   resetHighVolt,
    output logic                                   byteSel,
    output logic [flash_ctrl_pkg::ADDR_W-1:0]      addrPin,
    output logic [flash_ctrl_pkg::DATA_W-1:0]      dataOut,
    output logic                                   dataOe_n,
    input  wire logic [flash_ctrl_pkg::DATA_W-1:0] dataIn
);
    import flash_ctrl_pkg::*;

    typedef enum logic [2:0] {IDLE, CMD, RDSTAT, DONE} state_t;

    state_t               state;
    req_t                 cur;
    logic [2:0]           step;
    logic [2:0]           nSteps;
    logic                 cycStart;
    cycle_t               cyc;
    logic                 cycBusy;
    logic                 cycDone;
    logic [DATA_W-1:0]    cycData;
    logic                 pollPhase;
    logic                 havePrev;
    logic [DATA_W-1:0]    prevRead;
    logic [31:0]          pollCnt;

    // Builds one write cycle with the command in the low byte
    function automatic cycle_t wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        cycle_t c;
        c.addr  = a;
        c.data  = {8'h00, d};
        c.write = 1'b1;
        return c;
    endfunction

    // Byte mode shifts the address right by one and drops its low bit
    function automatic logic [ADDR_W-1:0] pinAddr(input req_t r);
        return r.byteMode ? (r.addr >> 1) : r.addr;
    endfunction

    // ****************************************
    // Bus cycle engine
    // ****************************************
    flash_bus_cycle u_cycle (
        .clk        (clk),
        .rst        (rst),
        .start      (cycStart),
        .cyc        (cyc),
        .busy       (cycBusy),
        .done       (cycDone),
        .rdData     (cycData),
        .chipSel_n  (chipSel_n),
        .outEn_n    (outEn_n),
        .writeStb_n (writeStb_n),
        .addrPin    (addrPin),
        .dataOut    (dataOut),
        .dataOe_n   (dataOe_n),
        .dataIn     (dataIn)
    );

    assign reqReady = (state == IDLE);

    // ****************************************
    // Command step table
    // ****************************************
    always_comb begin
        cyc    = wr(UNLOCK_ADDR1, UNLOCK_DATA1);
        nSteps = 3'd6;
        unique case (cur.op)
            OP_READ: begin
                nSteps     = 3'd1;
                cyc.addr   = pinAddr(cur);
                cyc.data   = '0;
                cyc.write  = 1'b0;
            end
            OP_PROGRAM: nSteps = 3'd4;
            OP_LOCK_QUERY: nSteps = 3'd7;
            default: nSteps = 3'd6;
        endcase
        if (cur.op != OP_READ) begin
            unique case (step)
                3'd0: cyc = wr(UNLOCK_ADDR1, UNLOCK_DATA1);
                3'd1: cyc = wr(UNLOCK_ADDR2, UNLOCK_DATA2);
                3'd2: cyc = wr(UNLOCK_ADDR1, (cur.op == OP_PROGRAM) ? CMD_PROGRAM :
                               (cur.op == OP_LOCK_QUERY) ? CMD_ID_ENTRY : CMD_ERASE_PRE);
                3'd3: begin
                    if (cur.op == OP_PROGRAM) begin
                        cyc      = wr(pinAddr(cur), 8'h00);
                        cyc.data = cur.byteMode ? {8'h00, cur.data[7:0]} : cur.data;
                    end else if (cur.op == OP_LOCK_QUERY) begin
                        cyc       = wr(LOCK_STAT_ADDR, 8'h00);
                        cyc.write = 1'b0;
                    end else begin
                        cyc = wr(UNLOCK_ADDR1, UNLOCK_DATA1);
                    end
                end
                3'd4: cyc = wr((cur.op == OP_LOCK_QUERY) ? UNLOCK_ADDR1 : UNLOCK_ADDR2,
                               (cur.op == OP_LOCK_QUERY) ? UNLOCK_DATA1 : UNLOCK_DATA2);
                3'd5: begin
                    unique case (cur.op)
                        OP_CHIP_ERASE: cyc = wr(UNLOCK_ADDR1, CMD_CHIP_ERASE);
                        // Erase order across blocks set by caller
                        OP_SECT_ERASE: cyc = wr(cur.addr, CMD_SECT_ERASE);
                        OP_LOCKOUT: cyc = wr(UNLOCK_ADDR1, CMD_LOCKOUT);
                        default: cyc = wr(UNLOCK_ADDR2, UNLOCK_DATA2);
                    endcase
                end
                default: cyc = wr(UNLOCK_ADDR1, CMD_ID_EXIT);
            endcase
            if (pollPhase) begin
                cyc.addr  = (cur.op == OP_PROGRAM) ? pinAddr(cur) : '0;
                cyc.data  = '0;
                cyc.write = 1'b0;
            end
        end
    end

    // ****************************************
    // Reset and width pins
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flashReset_n  <= 1'b0;
            resetHighVolt <= 1'b0;
            byteSel       <= 1'b1;
        end else begin
            flashReset_n  <= !abort;
            resetHighVolt <= overrideLock && (state != IDLE);
            if (reqValid && reqReady) begin
                byteSel <= !req.byteMode;
            end
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= IDLE;
            cur       <= '0;
            step      <= '0;
            cycStart  <= 1'b0;
            pollPhase <= 1'b0;
            havePrev  <= 1'b0;
            prevRead  <= '0;
            pollCnt   <= '0;
            rsp       <= '0;
        end else begin
            cycStart <= 1'b0;
            rsp.done <= 1'b0;
            unique case (state)
                IDLE: begin
                    if (reqValid) begin
                        cur       <= req;
                        step      <= '0;
                        pollPhase <= 1'b0;
                        havePrev  <= 1'b0;
                        pollCnt   <= '0;
                        cycStart  <= 1'b1;
                        state     <= CMD;
                    end
                end
                CMD: begin
                    if (abort && !cycBusy && !cycStart) begin
                        rsp.timeout <= 1'b1;
                        state       <= DONE;
                    end else if (cycDone) begin
                        if (cur.op == OP_LOCK_QUERY && step == 3'd3) begin
                            rsp.data <= {15'h0000, cycData[DQ_LOCK]};
                        end
                        if (cur.op == OP_READ) begin
                            rsp.data <= cycData;
                        end
                        if (step == nSteps - 3'd1 || pollPhase) begin
                            if (cur.op == OP_READ || cur.op == OP_LOCK_QUERY) begin
                                state <= DONE;
                            end else begin
                                state <= RDSTAT;
                            end
                        end else begin
                            step     <= step + 3'd1;
                            cycStart <= 1'b1;
                        end
                    end
                end
                RDSTAT: begin
                    pollPhase <= 1'b1;
                    if (abort) begin
                        rsp.timeout <= 1'b1;
                        state       <= DONE;
                    end else if (!pollPhase) begin
                        cycStart <= 1'b1;
                        state    <= CMD;
                    end else if (havePrev &&
                                 cycData[DQ_TOGGLE] == prevRead[DQ_TOGGLE]) begin
                        rsp.timeout <= 1'b0;
                        rsp.data    <= cycData;
                        state       <= DONE;
                    end else if (pollCnt == 32'(POLL_LIMIT)) begin
                        rsp.timeout <= 1'b1;
                        state       <= DONE;
                    end else begin
                        havePrev <= 1'b1;
                        prevRead <= cycData;
                        pollCnt  <= pollCnt + 32'd1;
                        cycStart <= 1'b1;
                        state    <= CMD;
                    end
                end
                DONE: begin
                    rsp.done <= 1'b1;
                    state    <= IDLE;
                end
                default: state <= IDLE;
            endcase
            if (state == IDLE && reqValid) begin
                rsp.timeout <= 1'b0;
            end
        end
    end

endmodule

// file: sim/flash_host_ctrl_chk.sv
// Checker for the flash host controller pins and request handshake.
// Assumes a bind onto flash_host_ctrl; sees only its ports.
`timescale 1ns/1ps
module flash_host_ctrl_chk (
    // Clock and reset
    input wire logic                         clk,
    input wire logic                         rst,
    // User side
    input wire logic                         reqValid,
    input wire logic                         reqReady,
    input wire flash_ctrl_pkg::req_t         req,
    input wire flash_ctrl_pkg::rsp_t         rsp,
    input wire logic                         abort,
    input wire logic                         overrideLock,
    // Flash pins
    input wire logic                         chipSel_n,
    input wire logic                         outEn_n,
    input wire logic                         writeStb_n,
    input wire logic                         flashReset_n,
    input wire logic                         resetHighVolt,
    input wire logic                         byteSel,
    input wire logic [16:0]                  addrPin,
    input wire logic [15:0]                  dataOut,
    input wire logic                         dataOe_n,
    input wire logic [15:0]                  dataIn
);
    import flash_ctrl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    AST_WR_OE: assert property (!writeStb_n |-> outEn_n && !dataOe_n && !chipSel_n)
        else $error("write strobe misuse");
    AST_RD_WE: assert property (!outEn_n |-> writeStb_n && dataOe_n)
        else $error("read overlaps write");
    AST_ADDR_SET: assert property ($fell(writeStb_n) |-> $stable(addrPin) && !$past(chipSel_n, 2))
        else $error("address not set before strobe");
    AST_WR_HOLD: assert property (!writeStb_n && !$past(writeStb_n)
        |-> $stable(addrPin) && $stable(dataOut))
        else $error("bus moved under strobe");
    AST_WR_WIDTH: assert property ($fell(writeStb_n) |-> !writeStb_n [*8] ##[1:8] writeStb_n)
        else $error("write strobe width");
    AST_RD_WIDTH: assert property ($fell(outEn_n) |-> !outEn_n [*8] ##[1:40] outEn_n)
        else $error("read strobe width");
    AST_DONE_PULSE: assert property (rsp.done |=> !rsp.done)
        else $error("done longer than one cycle");
    AST_ABORT: assert property (abort |=> !flashReset_n)
        else $error("abort did not reset flash");
    AST_IDLE: assert property (reqReady |-> chipSel_n && outEn_n && writeStb_n)
        else $error("strobe active while idle");
endmodule

// file: sim/flash_part_model.sv
// Behavioural flash part on the controller's pins.
// Assumes word storage; byte mode shows the low byte of the addressed word.
`timescale 1ns/1ps
module flash_part_model #(
    parameter int PROG_NS  = 1000,
    parameter int ERASE_NS = 4000
) (
    // Flash pins
    input wire logic        chipSel_n,
    input wire logic        outEn_n,
    input wire logic        writeStb_n,
    input wire logic        flashReset_n,
    input wire logic        resetHighVolt,
    input wire logic        byteSel,
    input wire logic [16:0] addrPin,
    input wire logic [15:0] dataOut,
    output logic     [15:0] q
);
    import flash_ctrl_pkg::*;
    logic [15:0] mem [int];
    logic [16:0] adr, pa;
    logic [15:0] v = 16'h0000;
    logic        busy = 0, tog = 0, pol = 0, lock = 0, idm = 0;
    int          st = 0, gen = 0;
    wire  [7:0]  d = dataOut[7:0];
    wire         wr = chipSel_n | writeStb_n;
    wire         rd = chipSel_n | outEn_n | !writeStb_n;

    function automatic logic [15:0] rdw(int a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction
    function automatic int sect(int a);
        return a < 'h2000 ? 0 : a < 'h3000 ? 1 : a < 'h4000 ? 2 : 3;
    endfunction
    function automatic bit ok(int a);
        return !(lock && sect(a) == 0 && !resetHighVolt);
    endfunction
    task automatic run(int t, logic p);
        int g;
        gen++;
        g = gen;
        busy = 1;
        pol = p;
        fork begin
            #(t);
            if (g == gen) busy = 0;
        end join_none
    endtask
    // erase by sector or whole chip
    task automatic erase(int s);
        int ks[$];
        foreach (mem[k]) if ((s < 0 || sect(k) == s) && ok(k)) ks.push_back(k);
        foreach (ks[i]) mem.delete(ks[i]);
        run(ERASE_NS, 1'b0);
    endtask

    always @(negedge wr) adr = addrPin;
    always @(posedge wr) begin
        if (flashReset_n && outEn_n && !busy) begin
            case (st)
                0: st = (adr == UNLOCK_ADDR1 && d == UNLOCK_DATA1) ? 1 : 0;
                1: st = (adr == UNLOCK_ADDR2 && d == UNLOCK_DATA2) ? 2 : 0;
                2: begin
                    if (d == CMD_ID_ENTRY) idm = 1;
                    if (d == CMD_ID_EXIT) idm = 0;
                    st = d == CMD_ERASE_PRE ? 3 : d == CMD_PROGRAM ? 9 : 0;
                end
                3: st = (d == UNLOCK_DATA1) ? 4 : 0;
                4: st = (d == UNLOCK_DATA2) ? 5 : 0;
                5: begin
                    if (d == CMD_CHIP_ERASE) erase(-1);
                    if (d == CMD_SECT_ERASE) erase(sect(adr));
                    if (d == CMD_LOCKOUT) lock = 1;
                    st = 0;
                end
                9: begin
                    if (ok(adr)) begin
                        pa = adr;
                        mem[pa] = rdw(pa) & dataOut;
                        run(PROG_NS, ~dataOut[7]);
                    end
                    st = 0;
                end
                default: st = 0;
            endcase
        end
    end
    // reset aborts and spoils the word in flight
    always @(negedge flashReset_n) begin
        if (busy) mem[pa] = 16'h0BAD;
        gen++;
        busy = 0;
        st = 0;
        idm = 0;
    end
    always @(negedge rd) begin
        if (busy) tog = ~tog;
        v = (idm && addrPin == LOCK_STAT_ADDR) ? {15'h0000, lock}
          : busy ? {8'h00, pol, tog, 6'h00} : rdw(addrPin);
    end
    // drive only when selected, else a changed value
    assign q = (!rd && flashReset_n) ? (byteSel ? v : {~v[15:8], v[7:0]}) : ~v;
endmodule

// file: sim/tb_top.sv
// Self-checking bench: host controller against the flash part model.
// Assumes checker and part model are compiled first.
`timescale 1ns/1ps
bind flash_host_ctrl flash_host_ctrl_chk chk (.clk, .rst, .reqValid, .reqReady, .req,
    .rsp, .abort, .overrideLock, .chipSel_n, .outEn_n, .writeStb_n, .flashReset_n,
    .resetHighVolt, .byteSel, .addrPin, .dataOut, .dataOe_n, .dataIn);
module tb_top;
    import flash_ctrl_pkg::*;
    logic        clk = 0, rst = 1, reqValid = 0, abort = 0, overrideLock = 0;
    logic        reqReady, chipSel_n, outEn_n, writeStb_n, flashReset_n;
    logic        resetHighVolt, byteSel, dataOe_n;
    logic [16:0] addrPin;
    logic [15:0] dataOut, dataIn, q;
    req_t        req = '0;
    rsp_t        rsp;
    int          failures = 0, checks_done = 0;

    flash_host_ctrl uut (.clk, .rst, .reqValid, .reqReady, .req, .rsp, .abort,
        .overrideLock, .chipSel_n, .outEn_n, .writeStb_n, .flashReset_n,
        .resetHighVolt, .byteSel, .addrPin, .dataOut, .dataOe_n, .dataIn);
    flash_part_model fm (.chipSel_n, .outEn_n, .writeStb_n, .flashReset_n,
        .resetHighVolt, .byteSel, .addrPin, .dataOut, .q);
    assign dataIn = dataOe_n ? q : dataOut;

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check16(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_op(op_t o, logic [16:0] a, logic [15:0] d, logic wordMode);
        int n;
        @(negedge clk);
        req = '{o, a, d, !wordMode};
        reqValid = 1;
        for (n = 0; n < 100 && reqReady !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        reqValid = 0;
        for (n = 0; n < 20000 && rsp.done !== 1'b1; n++) @(negedge clk);
        if (n >= 20000) failures++;
    endtask
    task automatic rd_chk(string w, logic [16:0] a, logic [15:0] e);
        do_op(OP_READ, a, 16'h0000, 1'b1);
        check16(w, e, rsp.data);
    endtask

    task automatic t_program;
        rd_chk("erased word", 17'h04000, 16'hFFFF);
        do_op(OP_PROGRAM, 17'h04000, 16'h1234, 1'b1);
        rd_chk("programmed", 17'h04000, 16'h1234);
        check16("word select", 16'h0001, {15'h0000, byteSel});
        do_op(OP_PROGRAM, 17'h04000, 16'hFF0F, 1'b1);
        rd_chk("bits only clear", 17'h04000, 16'h1204);
        rd_chk("command address", UNLOCK_ADDR1, 16'hFFFF);
        $display("test program done");
    endtask
    task automatic t_byte;
        do_op(OP_PROGRAM, 17'h04001, 16'hA55A, 1'b1);
        do_op(OP_READ, 17'h08002, 16'h0000, 1'b0);
        check16("byte read", 16'h005A, {8'h00, rsp.data[7:0]});
        check16("byte select", 16'h0000, {15'h0000, byteSel});
        $display("test byte done");
    endtask
    task automatic t_abort;
        int n;
        @(negedge clk);
        req = '{OP_PROGRAM, 17'h05000, 16'h0000, 1'b1};
        reqValid = 1;
        repeat (2) @(negedge clk);
        reqValid = 0;
        repeat (150) @(negedge clk);
        abort = 1;
        for (n = 0; n < 200 && rsp.done !== 1'b1; n++) @(negedge clk);
        check16("abort timeout", 16'h0001, {15'h0000, rsp.timeout});
        check16("flash reset", 16'h0000, {15'h0000, flashReset_n});
        abort = 0;
        rd_chk("read after abort", 17'h04001, 16'hA55A);
        $display("test abort done");
    endtask
    task automatic t_sector;
        do_op(OP_PROGRAM, 17'h02100, 16'h0F0F, 1'b1);
        do_op(OP_SECT_ERASE, SECT_MAIN, 16'h0000, 1'b1);
        rd_chk("main erased", 17'h04001, 16'hFFFF);
        rd_chk("param kept", 17'h02100, 16'h0F0F);
        $display("test sector done");
    endtask
    task automatic t_lock;
        do_op(OP_PROGRAM, 17'h00010, 16'h1111, 1'b1);
        do_op(OP_LOCK_QUERY, 17'h00000, 16'h0000, 1'b1);
        check16("lock clear", 16'h0000, {15'h0000, rsp.data[0]});
        do_op(OP_LOCKOUT, 17'h00000, 16'h0000, 1'b1);
        do_op(OP_LOCK_QUERY, 17'h00000, 16'h0000, 1'b1);
        check16("lock set", 16'h0001, {15'h0000, rsp.data[0]});
        do_op(OP_PROGRAM, 17'h00011, 16'h2222, 1'b1);
        rd_chk("boot refused", 17'h00011, 16'hFFFF);
        do_op(OP_CHIP_ERASE, 17'h00000, 16'h0000, 1'b1);
        rd_chk("boot kept", 17'h00010, 16'h1111);
        rd_chk("param erased", 17'h02100, 16'hFFFF);
        overrideLock = 1;
        do_op(OP_PROGRAM, 17'h00011, 16'h2222, 1'b1);
        overrideLock = 0;
        rd_chk("boot override", 17'h00011, 16'h2222);
        $display("test lock done");
    endtask

    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 0;
        t_program();
        t_byte();
        t_abort();
        t_sector();
        t_lock();
        report_and_stop();
    end
endmodule
